/* rtl/hom_pkg.sv */
// package: shared types and constants of the homing sequencer for methods 15 to 26
package hom_pkg;

    localparam int POS_W = 32;
    localparam int METH_W = 8;
    localparam int IDX_W = 2;

    // method numbers as selected by the controlling party
    localparam logic [METH_W-1:0] M15 = 8'h0F;
    localparam logic [METH_W-1:0] M16 = 8'h10;
    localparam logic [METH_W-1:0] M17 = 8'h11;
    localparam logic [METH_W-1:0] M18 = 8'h12;
    localparam logic [METH_W-1:0] M19 = 8'h13;
    localparam logic [METH_W-1:0] M20 = 8'h14;
    localparam logic [METH_W-1:0] M21 = 8'h15;
    localparam logic [METH_W-1:0] M22 = 8'h16;
    localparam logic [METH_W-1:0] M23 = 8'h17;
    localparam logic [METH_W-1:0] M24 = 8'h18;
    localparam logic [METH_W-1:0] M25 = 8'h19;
    localparam logic [METH_W-1:0] M26 = 8'h1A;

    localparam logic SPD_FAST = 1'b1;
    localparam logic SPD_SLOW = 1'b0;
    localparam logic DIR_FWD = 1'b1;
    localparam logic DIR_REV = 1'b0;
    localparam logic EDGE_RISE = 1'b1;
    localparam logic EDGE_FALL = 1'b0;

    localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
    localparam logic [IDX_W-1:0] IDX_ONE = 2'h1;
    localparam logic [IDX_W-1:0] IDX_STEP = 2'h1;
    localparam logic [IDX_W-1:0] IDX_TWO = 2'h2;

    // switch vector index: reverse limit, forward limit, home switch
    typedef enum logic [1:0] {SIG_REV, SIG_FWD, SIG_HOME} hom_sig_e;
    // start condition: signal off, signal on, limit touched during fast search
    typedef enum logic [1:0] {VAR_A, VAR_B, VAR_C} hom_var_e;
    typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_STOP} hom_state_e;

    typedef struct packed {
        logic run;
        logic fwd;
        logic fast;
    } hom_motion_s;

    typedef struct packed {
        logic valid;
        logic fast;
        logic fwd;
        hom_sig_e sig;
        logic rise;
    } hom_step_s;

    localparam hom_motion_s MOTION_OFF = '{run: 1'b0, fwd: 1'b0, fast: 1'b0};
    localparam hom_step_s STEP_NONE = '{valid: 1'b0, fast: 1'b0, fwd: 1'b0,
                                        sig: SIG_REV, rise: 1'b0};
    localparam logic [2:0] SW_RESET = 3'h0;
    localparam logic [POS_W-1:0] POS_RESET = 32'h0;

endpackage

/* rtl/hom_sequencer.sv */
// homing sequencer: switch edge searches for methods 15 to 26 of a servo drive
//
// What this block does
// - method 15 takes present position as home and clears absolute position.
// - method 16 is reserved; a start with it is refused, nothing moves.
// - method 17: fast reverse to reverse limit rise, stop, slow forward to fall.
// - method 17 with reverse limit on: slow forward to its falling edge only.
// - method 18: fast forward to forward limit rise, stop, slow reverse to fall.
// - method 19: fast forward to home rise, stop, slow reverse to fall.
// - method 19 with home on: slow reverse to home falling edge only.
// - method 20: fast fwd rise, stop, slow rev fall, slow fwd rise; on: skip fast.
// - method 21: fast rev rise, stop, slow fwd fall; on: slow fwd only.
// - method 22: fast rev rise, stop, slow fwd fall, slow rev rise.
// - method 23: fast fwd rise, stop, slow rev fall; on: slow rev only.
// - method 23 limit hit: fast rev to fall, slow fwd rise, slow rev fall.
// - method 24: fast fwd rise, stop, slow rev fall, slow fwd rise; on: skip fast.
// - method 24 limit hit: fast rev to fall, stop, slow fwd to rise.
// - method 25: fast fwd to fall, stop, slow rev to rise.
// - method 25 limit hit: fast rev rise, stop, slow fwd fall, slow rev rise.
// - method 26: fast fwd to fall, stop, slow rev rise, slow fwd fall.
// - method 26 limit hit: fast rev to rise, stop, slow fwd to fall.
`timescale 1ns/1ps

module hom_sequencer (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_start,
    input wire logic [hom_pkg::METH_W-1:0] i_method,
    input wire logic i_home_sw,
    input wire logic i_fwd_lim,
    input wire logic i_rev_lim,
    input wire logic i_at_zero,
    input wire logic [hom_pkg::POS_W-1:0] i_position,
    output hom_pkg::hom_motion_s o_motion,
    output logic o_busy,
    output logic o_done,
    output logic o_reject,
    output logic o_abs_clear,
    output logic [hom_pkg::POS_W-1:0] o_home_pos
);
    import hom_pkg::*;
    default clocking cb_mclk @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    function automatic hom_step_s mk(input logic fast, input logic fwd,
                                     input hom_sig_e sig, input logic rise);
        return '{valid: 1'b1, fast: fast, fwd: fwd, sig: sig, rise: rise};
    endfunction

    // step table: one entry per edge search, indexed by method, start case and step
    function automatic hom_step_s step_of(input logic [METH_W-1:0] m, input hom_var_e v,
                                          input logic [IDX_W-1:0] ix);
        hom_step_s s0;
        hom_step_s s1;
        hom_step_s s2;
        hom_step_s r;
        s0 = STEP_NONE;
        s1 = STEP_NONE;
        s2 = STEP_NONE;
        case (m)
            M17: begin
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_REV, SIG_REV, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_REV, EDGE_FALL);
                end else begin
                    s0 = mk(SPD_SLOW, DIR_FWD, SIG_REV, EDGE_FALL);
                end
            end
            M18: begin
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_FWD, SIG_FWD, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_REV, SIG_FWD, EDGE_FALL);
                end else begin
                    s0 = mk(SPD_SLOW, DIR_REV, SIG_FWD, EDGE_FALL);
                end
            end
            M19: begin
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_FWD, SIG_HOME, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                end else begin
                    s0 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                end
            end
            M20, M24: begin
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_FWD, SIG_HOME, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                    s2 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_RISE);
                end else if (v == VAR_B) begin
                    s0 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_RISE);
                end else begin
                    s0 = mk(SPD_FAST, DIR_REV, SIG_HOME, EDGE_FALL);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_RISE);
                end
            end
            M21: begin
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_REV, SIG_HOME, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_FALL);
                end else begin
                    s0 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_FALL);
                end
            end
            M22: begin
                // switch already on: begin at the slow forward step, as the fast one is moot
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_REV, SIG_HOME, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_FALL);
                    s2 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_RISE);
                end else begin
                    s0 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_FALL);
                    s1 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_RISE);
                end
            end
            M23: begin
                if (v == VAR_A) begin
                    s0 = mk(SPD_FAST, DIR_FWD, SIG_HOME, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                end else if (v == VAR_B) begin
                    s0 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                end else begin
                    s0 = mk(SPD_FAST, DIR_REV, SIG_HOME, EDGE_FALL);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_RISE);
                    s2 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_FALL);
                end
            end
            M25, M26: begin
                if (v != VAR_C) begin
                    s0 = mk(SPD_FAST, DIR_FWD, SIG_HOME, EDGE_FALL);
                    s1 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_RISE);
                    if (m == M26) begin
                        s2 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_FALL);
                    end
                end else begin
                    s0 = mk(SPD_FAST, DIR_REV, SIG_HOME, EDGE_RISE);
                    s1 = mk(SPD_SLOW, DIR_FWD, SIG_HOME, EDGE_FALL);
                    if (m == M25) begin
                        s2 = mk(SPD_SLOW, DIR_REV, SIG_HOME, EDGE_RISE);
                    end
                end
            end
            default: s0 = STEP_NONE;
        endcase
        if (ix == IDX_FIRST) begin
            r = s0;
        end else if (ix == IDX_ONE) begin
            r = s1;
        end else if (ix == IDX_TWO) begin
            r = s2;
        end else begin
            r = STEP_NONE;
        end
        return r;
    endfunction

    function automatic logic limit_reverses(input logic [METH_W-1:0] m);
        return (m == M23) || (m == M24) || (m == M25) || (m == M26);
    endfunction

    function automatic hom_motion_s motion_of(input hom_step_s s);
        return '{run: s.valid, fwd: s.fwd, fast: s.fast};
    endfunction

    // switch pins are asynchronous: two flops, then one more for edge detection
    logic [2:0] sw_meta_q, sw_sync_q, sw_prev_q;
    logic [2:0] sw_rise, sw_fall;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sw_meta_q <= SW_RESET;
            sw_sync_q <= SW_RESET;
            sw_prev_q <= SW_RESET;
        end else begin
            sw_meta_q <= {i_home_sw, i_fwd_lim, i_rev_lim};
            sw_sync_q <= sw_meta_q;
            sw_prev_q <= sw_sync_q;
        end
    end

    assign sw_rise = sw_sync_q & ~sw_prev_q;
    assign sw_fall = ~sw_sync_q & sw_prev_q;

    hom_state_e state_q;
    hom_var_e var_q, var_d;
    logic [METH_W-1:0] meth_q;
    logic [IDX_W-1:0] idx_q;
    hom_step_s cur, nxt;
    logic idle_start, edge_hit, limit_hit, finish, is_motion_method;

    assign idle_start = i_start && (state_q == ST_IDLE);
    assign is_motion_method = step_of(i_method, VAR_A, IDX_FIRST).valid;

    // start case: the switch searched for first decides whether the fast pass is skipped, except in methods 25 and 26, which always start fast
    always_comb begin
        var_d = VAR_A;
        if (i_method == M17) begin
            var_d = sw_sync_q[SIG_REV] ? VAR_B : VAR_A;
        end else if (i_method == M18) begin
            var_d = sw_sync_q[SIG_FWD] ? VAR_B : VAR_A;
        end else begin
            var_d = sw_sync_q[SIG_HOME] ? VAR_B : VAR_A;
        end
    end

    assign cur = step_of(meth_q, var_q, idx_q);
    assign nxt = step_of(meth_q, var_q, idx_q + IDX_STEP);
    assign edge_hit = (state_q == ST_MOVE) && cur.valid &&
                      (cur.rise ? sw_rise[cur.sig] : sw_fall[cur.sig]);
    // limit only turns the search round during the first fast forward pass
    assign limit_hit = (state_q == ST_MOVE) && limit_reverses(meth_q) && (var_q != VAR_C) &&
                       cur.fast && cur.fwd && sw_rise[SIG_FWD];
    assign finish = edge_hit && !limit_hit && !cur.fast && !nxt.valid;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_q <= ST_IDLE;
            var_q <= VAR_A;
            meth_q <= M15;
            idx_q <= IDX_FIRST;
            o_motion <= MOTION_OFF;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (idle_start && is_motion_method) begin
                        meth_q <= i_method;
                        var_q <= var_d;
                        idx_q <= IDX_FIRST;
                        o_motion <= motion_of(step_of(i_method, var_d, IDX_FIRST));
                        state_q <= ST_MOVE;
                    end
                end
                ST_MOVE: begin
                    if (limit_hit) begin
                        var_q <= VAR_C;
                        idx_q <= IDX_FIRST;
                        o_motion <= MOTION_OFF;
                        state_q <= ST_STOP;
                    end else if (edge_hit && cur.fast) begin
                        idx_q <= idx_q + IDX_STEP;
                        o_motion <= MOTION_OFF;
                        state_q <= ST_STOP;
                    end else if (edge_hit && nxt.valid) begin
                        // slow to slow: direction flips without a deceleration wait
                        idx_q <= idx_q + IDX_STEP;
                        o_motion <= motion_of(nxt);
                    end else if (finish) begin
                        o_motion <= MOTION_OFF;
                        state_q <= ST_IDLE;
                    end
                end
                ST_STOP: begin
                    // wait for zero speed before reversing
                    if (i_at_zero) begin
                        o_motion <= motion_of(cur);
                        state_q <= ST_MOVE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_home_pos <= POS_RESET;
            o_done <= 1'b0;
            o_abs_clear <= 1'b0;
            o_reject <= 1'b0;
        end else begin
            o_done <= 1'b0;
            o_abs_clear <= 1'b0;
            o_reject <= 1'b0;
            if (idle_start && (i_method == M15)) begin
                o_home_pos <= i_position;
                o_abs_clear <= 1'b1;
                o_done <= 1'b1;
            end else if (idle_start && !is_motion_method) begin
                o_reject <= 1'b1;
            end else if (finish) begin
                o_home_pos <= i_position;
                o_done <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_busy <= 1'b0;
        end else begin
            o_busy <= (idle_start && is_motion_method) ||
                      ((state_q != ST_IDLE) && !finish);
        end
    end

    property p_m15_home;
        idle_start && (i_method == M15) |=>
            o_abs_clear && o_done && (o_home_pos == $past(i_position)) && !o_motion.run;
    endproperty
    a_m15_home: assert property (p_m15_home) else $error("method 15 did not set home");
    property p_m16_refused;
        idle_start && (i_method == M16) |=> o_reject ##0 (!o_busy && !o_motion.run) [*2];
    endproperty
    a_m16_refused: assert property (p_m16_refused) else $error("method 16 not refused");
    property p_m17_fast;
        idle_start && (i_method == M17) && !sw_sync_q[SIG_REV] |=>
            o_motion.run && o_motion.fast && !o_motion.fwd && o_busy;
    endproperty
    a_m17_fast: assert property (p_m17_fast) else $error("method 17 fast reverse missing");
    property p_m17_on;
        idle_start && (i_method == M17) && sw_sync_q[SIG_REV] |=>
            o_motion.run && !o_motion.fast && o_motion.fwd;
    endproperty
    a_m17_on: assert property (p_m17_on) else $error("method 17 skip of fast pass wrong");
    property p_m18_fast;
        idle_start && (i_method == M18) && !sw_sync_q[SIG_FWD] |=>
            o_motion.run && o_motion.fast && o_motion.fwd;
    endproperty
    a_m18_fast: assert property (p_m18_fast) else $error("method 18 fast forward missing");
    property p_m18_on;
        idle_start && (i_method == M18) && sw_sync_q[SIG_FWD] |=>
            o_motion.run && !o_motion.fast && !o_motion.fwd;
    endproperty
    a_m18_on: assert property (p_m18_on) else $error("method 18 slow reverse missing");
    property p_m19_on;
        idle_start && (i_method == M19) && sw_sync_q[SIG_HOME] |=>
            o_motion.run && !o_motion.fast && !o_motion.fwd;
    endproperty
    a_m19_on: assert property (p_m19_on) else $error("method 19 slow reverse missing");
    property p_fast_decel;
        edge_hit && cur.fast && !limit_hit |=>
            !o_motion.run && (state_q == ST_STOP) && o_busy;
    endproperty
    a_fast_decel: assert property (p_fast_decel) else $error("fast search not stopped");
    property p_limit_turn;
        limit_hit |=>
            (var_q == VAR_C) && (state_q == ST_STOP) && (idx_q == IDX_FIRST) && !o_motion.run;
    endproperty
    a_limit_turn: assert property (p_limit_turn) else $error("limit did not turn search");
    property p_limit_back;
        (state_q == ST_STOP) && i_at_zero && (var_q == VAR_C) && (idx_q == IDX_FIRST) |=>
            o_motion.run && o_motion.fast && !o_motion.fwd;
    endproperty
    a_limit_back: assert property (p_limit_back) else $error("no fast reverse after limit");
    property p_done_stops;
        finish |=> o_done && !o_motion.run && !o_busy && (o_home_pos == $past(i_position));
    endproperty
    a_done_stops: assert property (p_done_stops) else $error("final stop not latched");
    property p_cov_m23_limit;
        limit_hit && (meth_q == M23);
    endproperty
    c_m23_limit: cover property (p_cov_m23_limit);
    property p_cov_m20_done;
        finish && (meth_q == M20) && (var_q == VAR_A);
    endproperty
    c_m20_done: cover property (p_cov_m20_done);
    property p_cov_m15;
        idle_start && (i_method == M15);
    endproperty
    c_m15: cover property (p_cov_m15);

endmodule

/* verification/hom_axis_model.sv */
// axis model: carriage with home switch region, both limit switches and speed decay
`timescale 1ns/1ps

module hom_axis_model #(
    parameter int ZERO_DLY = 4,
    parameter int REV_EDGE = 100,
    parameter int FWD_EDGE = 900,
    parameter int HOME_LO = 400,
    parameter int HOME_HI = 600
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input hom_pkg::hom_motion_s i_motion,
    input wire logic i_load,
    input wire logic [hom_pkg::POS_W-1:0] i_load_pos,
    output logic o_home_sw,
    output logic o_fwd_lim,
    output logic o_rev_lim,
    output logic o_at_zero,
    output logic [hom_pkg::POS_W-1:0] o_position
);
    import hom_pkg::*;
    int pos_q;
    int still_q;
    // switches follow the carriage, so every edge is a real crossing
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            pos_q <= 300;
        end else if (i_load) begin
            pos_q <= int'(i_load_pos);
        end else if (i_motion.run) begin
            pos_q <= pos_q + (i_motion.fwd ? 1 : -1) * (i_motion.fast ? 4 : 1);
        end
    end
    // zero speed only after a decay time, never at once
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            still_q <= 0;
        end else if (i_motion.run) begin
            still_q <= 0;
        end else if (still_q < ZERO_DLY) begin
            still_q <= still_q + 1;
        end
    end
    assign o_at_zero = (still_q >= ZERO_DLY);
    assign o_rev_lim = (pos_q < REV_EDGE);
    assign o_fwd_lim = (pos_q > FWD_EDGE);
    assign o_home_sw = (pos_q >= HOME_LO) && (pos_q < HOME_HI);
    assign o_position = 32'(pos_q);
endmodule

/* verification/tb.sv */
// testbench: homing methods 15 to 26 against a moving axis model
`timescale 1ns/1ps

module tb;
    import hom_pkg::*;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_start = 1'b0;
    logic [METH_W-1:0] i_method = M15;
    logic i_load = 1'b0;
    logic [POS_W-1:0] load_pos = 32'h0;
    logic home_sw, fwd_lim, rev_lim, at_zero;
    logic [POS_W-1:0] position;
    logic [POS_W-1:0] o_home_pos;
    hom_motion_s o_motion;
    logic o_busy, o_done, o_reject, o_abs_clear;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    always #5 i_mclk = ~i_mclk;

    hom_axis_model #(.ZERO_DLY(5)) hom_axis_model_inst (.i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst), .i_motion(o_motion), .i_load(i_load), .i_load_pos(load_pos),
        .o_home_sw(home_sw), .o_fwd_lim(fwd_lim), .o_rev_lim(rev_lim), .o_at_zero(at_zero),
        .o_position(position));
    hom_sequencer hom_sequencer_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
        .i_start(i_start), .i_method(i_method), .i_home_sw(home_sw), .i_fwd_lim(fwd_lim),
        .i_rev_lim(rev_lim), .i_at_zero(at_zero), .i_position(position),
        .o_motion(o_motion), .o_busy(o_busy), .o_done(o_done), .o_reject(o_reject),
        .o_abs_clear(o_abs_clear), .o_home_pos(o_home_pos));

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [POS_W-1:0] exp,
                       input logic [POS_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // final position lands a few slow steps past the edge: sync lag
    task automatic chk_rng(input string what, input int lo, input logic [POS_W-1:0] got);
        checks_done++;
        if ((int'(got) >= lo && int'(got) <= lo + 6) !== 1'b1) begin
            err_total++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, lo + 6, got);
        end
    endtask

    task automatic load_axis(input int p);
        @(posedge i_mclk);
        i_load <= 1'b1;
        load_pos <= 32'(p);
        @(posedge i_mclk);
        i_load <= 1'b0;
        repeat (6) @(posedge i_mclk);
    endtask

    task automatic kick(input logic [METH_W-1:0] m);
        @(posedge i_mclk);
        i_start <= 1'b1;
        i_method <= m;
        @(posedge i_mclk);
        i_start <= 1'b0;
        #1;
    endtask

    task automatic await_done(input int lo);
        int n;
        n = 0;
        while (o_done !== 1'b1 && n < 8000) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        chk("done_seen", 32'h1, 32'(o_done));
        chk_rng("home_pos", lo, o_home_pos);
        chk("busy_at_done", 32'h0, 32'(o_busy));
        chk("run_at_done", 32'h0, 32'(o_motion.run));
        @(posedge i_mclk);
        #1;
        chk("done_pulse", 32'h0, 32'(o_done));
    endtask

    // first step shows speed and direction, the stop place shows the edges taken
    task automatic home_run(input logic [METH_W-1:0] m, input int p, input logic [2:0] mot,
                            input int lo);
        load_axis(p);
        kick(m);
        chk("busy", 32'h1, 32'(o_busy));
        chk("first_motion", 32'(mot), 32'(o_motion));
        await_done(lo);
    endtask

    task automatic t_immediate();
        load_axis(1234);
        kick(M15);
        chk("done", 32'h1, 32'(o_done));
        chk("abs_clear", 32'h1, 32'(o_abs_clear));
        chk("home_pos", 32'h000004D2, o_home_pos);
        @(posedge i_mclk);
        #1;
        chk("abs_clear_pulse", 32'h0, 32'(o_abs_clear));
    endtask

    task automatic t_refuse();
        logic [METH_W-1:0] bad_m[3] = '{M16, 8'h0E, 8'h1B};
        foreach (bad_m[i]) begin
            kick(bad_m[i]);
            chk("reject", 32'h1, 32'(o_reject));
            chk("motion", 32'h0, 32'(o_motion));
            chk("busy", 32'h0, 32'(o_busy));
        end
    endtask

    task automatic t_busy_ignore();
        load_axis(300);
        kick(M19);
        repeat (3) @(posedge i_mclk);
        kick(M15);
        chk("abs_clear_busy", 32'h0, 32'(o_abs_clear));
        chk("busy_kept", 32'h1, 32'(o_busy));
        await_done(393);
    endtask

    task automatic t_limits();
        home_run(M17, 300, 3'b101, 100);
        home_run(M17, 50, 3'b110, 100);
        home_run(M18, 300, 3'b111, 894);
        home_run(M18, 950, 3'b100, 894);
    endtask

    task automatic t_home_plain();
        home_run(M19, 500, 3'b100, 393);
        home_run(M20, 300, 3'b111, 400);
        home_run(M20, 500, 3'b100, 400);
        home_run(M21, 700, 3'b101, 600);
        home_run(M21, 500, 3'b110, 600);
        home_run(M22, 700, 3'b101, 593);
    endtask

    task automatic t_limit_touch();
        home_run(M23, 300, 3'b111, 393);
        home_run(M23, 500, 3'b100, 393);
        home_run(M23, 650, 3'b111, 393);
        home_run(M24, 300, 3'b111, 400);
        home_run(M24, 500, 3'b100, 400);
        home_run(M24, 650, 3'b111, 400);
        home_run(M25, 300, 3'b111, 593);
        home_run(M25, 500, 3'b111, 593);
        home_run(M25, 650, 3'b111, 593);
        home_run(M26, 300, 3'b111, 600);
        home_run(M26, 500, 3'b111, 600);
        home_run(M26, 650, 3'b111, 600);
    endtask

    initial begin
        repeat (12) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        t_immediate();
        t_refuse();
        t_busy_ignore();
        t_limits();
        t_home_plain();
        t_limit_touch();
        stop_test();
    end

    // whole run needs about 2600 cycles
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            err_total++;
            stop_test();
        end
    end
endmodule
